/* File: rsx_alu_core.sv */
// Added by the designer: the placing of the registers and the plain strobed port.
`include "rsx_params.svh"
`default_nettype none

module rsx_alu_core #(
   parameter int FILE_DEPTH = 128
) (
   input  wire logic                    clk_sys,
   input  wire logic                    arst_n,
   input  wire logic                    ce,
   input  wire logic                    op_valid,
   input  wire rsx_pkg::rsx_req_t       op_req,
   input  wire rsx_pkg::rsx_bus_req_t   bus,
   output var  logic [7:0]              rd_data,
   output var  logic [7:0]              w_reg,
   output var  rsx_pkg::rsx_flags_t     flags,
   output var  logic                    op_done
);

   // ==========================================================================
   // Address and operation decode helpers
   function automatic logic addr_is_file(input logic [7:0] addr);
      addr_is_file = (addr <= `RSX_ADDR_FILE_MAX) && (int'(addr) < FILE_DEPTH);
   endfunction : addr_is_file

   function automatic logic op_uses_file(input rsx_pkg::rsx_op_t op);
      op_uses_file = (op == rsx_pkg::RSX_OP_ROTATE_RIGHT_VIA_CARRY) ||
                     (op == rsx_pkg::RSX_OP_SUBTRACT_FROM_FILE_REG) ||
                     (op == rsx_pkg::RSX_OP_XOR_WITH_FILE_REG) ||
                     (op == rsx_pkg::RSX_OP_NIBBLE_SWAP);
   endfunction : op_uses_file

   // ==========================================================================
   // Storage and datapath signals
   logic [7:0]          file_q [FILE_DEPTH];
   logic [7:0]          src_file;
   logic [6:0]          src_hi7;
   logic [7:0]          lit;
   logic [7:0]          sub_minuend;
   logic                op_take;
   logic [7:0]          next_result;
   rsx_pkg::rsx_flags_t next_flags;
   logic                next_to_w;
   logic                next_to_file;
   logic [7:0]          next_status;

   // Operands: the addressed file register and the literal
   assign op_take     = ce && op_valid;
   assign src_file    = file_q[op_req.file_addr];
   assign src_hi7     = src_file[7:1];
   assign lit         = op_req.literal;
   assign sub_minuend = (op_req.op == rsx_pkg::RSX_OP_SUBTRACT_FROM_IMMEDIATE) ? lit : src_file;

   // ==========================================================================
   // Result and flag computation, purely combinational
   always_comb begin
      next_result  = w_reg;
      next_flags   = flags;
      next_to_w    = 1'b0;
      next_to_file = 1'b0;
      case (op_req.op)
         rsx_pkg::RSX_OP_ROTATE_RIGHT_VIA_CARRY: begin
            next_result      = {flags.carry, src_file[7:1]};
            next_flags.carry = src_file[0];
         end
         rsx_pkg::RSX_OP_SUBTRACT_FROM_IMMEDIATE,
         rsx_pkg::RSX_OP_SUBTRACT_FROM_FILE_REG: begin
            // Modulo 256 difference; carry and digit carry report absence of borrow
            next_result                 = sub_minuend - w_reg;
            next_flags.carry            = (w_reg <= sub_minuend);
            next_flags.digit_carry_flag = (w_reg[3:0] <= sub_minuend[3:0]);
            next_flags.zero             = (next_result == 8'h00);
         end
         rsx_pkg::RSX_OP_XOR_WITH_IMMEDIATE: begin
            next_result     = w_reg ^ lit;
            next_flags.zero = (next_result == 8'h00);
         end
         rsx_pkg::RSX_OP_XOR_WITH_FILE_REG: begin
            next_result     = w_reg ^ src_file;
            next_flags.zero = (next_result == 8'h00);
         end
         rsx_pkg::RSX_OP_NIBBLE_SWAP: begin
            next_result = {src_file[3:0], src_file[7:4]};
         end
         default: begin
            next_result = w_reg;
         end
      endcase
      // Literal forms always land in W; file forms follow the select bit
      if (op_uses_file(op_req.op)) begin
         next_to_file = op_req.dest_file;
         next_to_w    = !op_req.dest_file;
      end else begin
         next_to_w = 1'b1;
      end
   end

   // ==========================================================================
   // File register array, one flop byte per entry
   // The operation wins over a software write to the same byte, so an
   // instruction result is never silently lost to a debug poke.
   genvar gi;
   generate
      for (gi = 0; gi < FILE_DEPTH; gi++) begin : g_file
         logic op_hit;
         logic bus_hit;
         assign op_hit  = op_take && next_to_file && (int'(op_req.file_addr) == gi);
         assign bus_hit = ce && bus.wr_stb && addr_is_file(bus.addr) && (int'(bus.addr) == gi);
         always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
               file_q[gi] <= `RSX_FILE_RESET;
            end else if (op_hit) begin
               file_q[gi] <= next_result;
            end else if (bus_hit) begin
               file_q[gi] <= bus.wdata;
            end
         end
      end
   endgenerate

   // ==========================================================================
   // Working register
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         w_reg <= `RSX_W_RESET;
      end else if (op_take && next_to_w) begin
         w_reg <= next_result;
      end else if (ce && bus.wr_stb && (bus.addr == `RSX_ADDR_W_REG)) begin
         w_reg <= bus.wdata;
      end
   end

   // ==========================================================================
   // Status flags; a taken operation drops a same-cycle software write
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         flags <= `RSX_STATUS_RESET;
      end else if (op_take) begin
         flags <= next_flags;
      end else if (ce && bus.wr_stb && (bus.addr == `RSX_ADDR_STATUS)) begin
         flags.carry            <= bus.wdata[`RSX_STAT_CARRY];
         flags.digit_carry_flag <= bus.wdata[`RSX_STAT_DIGIT];
         flags.zero             <= bus.wdata[`RSX_STAT_ZERO];
      end
   end

   // ==========================================================================
   // Completion pulse, one cycle per taken operation
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         op_done <= 1'b0;
      end else if (ce) begin
         op_done <= op_valid;
      end
   end

   // ==========================================================================
   // Software read port, data in the cycle after the strobe only
   always_comb begin
      next_status                 = 8'h00;
      next_status[`RSX_STAT_CARRY] = flags.carry;
      next_status[`RSX_STAT_DIGIT] = flags.digit_carry_flag;
      next_status[`RSX_STAT_ZERO]  = flags.zero;
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         rd_data <= `RSX_RDATA_RESET;
      end else if (ce) begin
         if (!bus.rd_stb) begin
            rd_data <= `RSX_RDATA_RESET;
         end else if (addr_is_file(bus.addr)) begin
            rd_data <= file_q[bus.addr[6:0]];
         end else if (bus.addr == `RSX_ADDR_W_REG) begin
            rd_data <= w_reg;
         end else if (bus.addr == `RSX_ADDR_STATUS) begin
            rd_data <= next_status;
         end else begin
            rd_data <= 8'h00;                                 // Unmapped reads zero
         end
      end
   end

   // ==========================================================================
   // Checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!arst_n);

   sequence s_take(rsx_pkg::rsx_op_t o);
      ce && op_valid && (op_req.op == o);
   endsequence

   sequence s_take_w(rsx_pkg::rsx_op_t o);
      ce && op_valid && (op_req.op == o) && !op_req.dest_file;
   endsequence

   sequence s_take_f(rsx_pkg::rsx_op_t o);
      ce && op_valid && (op_req.op == o) && op_req.dest_file;
   endsequence

   sequence s_idle;
      ce && !op_valid && !bus.wr_stb;
   endsequence

   AST_ROT_CARRY_OUT:
   assert property (s_take(rsx_pkg::RSX_OP_ROTATE_RIGHT_VIA_CARRY)
                    |=> flags.carry == $past(src_file[0]))
      else $error("rotate did not move bit 0 into carry");

   AST_ROT_TO_W:
   assert property (s_take_w(rsx_pkg::RSX_OP_ROTATE_RIGHT_VIA_CARRY)
                    |=> w_reg == {$past(flags.carry), $past(src_hi7)}
                        && flags.zero == $past(flags.zero))
      else $error("rotate result or untouched flags wrong");

   AST_DEST_FILE_KEEPS_W:
   assert property (ce && op_valid && op_uses_file(op_req.op) && op_req.dest_file
                    && !bus.wr_stb |=> w_reg == $past(w_reg))
      else $error("file destination disturbed the working register");

   AST_SUB_IMM_RESULT:
   assert property (s_take(rsx_pkg::RSX_OP_SUBTRACT_FROM_IMMEDIATE)
                    |=> w_reg == 8'($past(lit) - $past(w_reg)))
      else $error("immediate subtract result wrong");

   AST_SUB_CARRY:
   assert property ((s_take(rsx_pkg::RSX_OP_SUBTRACT_FROM_IMMEDIATE)
                     or s_take(rsx_pkg::RSX_OP_SUBTRACT_FROM_FILE_REG))
                    |=> flags.carry == ($past(w_reg) <= $past(sub_minuend)))
      else $error("subtract carry wrong");

   AST_SUB_FILE_TO_W:
   assert property (s_take_w(rsx_pkg::RSX_OP_SUBTRACT_FROM_FILE_REG)
                    |=> w_reg == 8'($past(src_file) - $past(w_reg))
                        && flags.zero == (w_reg == 8'h00))
      else $error("file subtract result or zero wrong");

   AST_XOR_IMM_FLAGS:
   assert property (s_take(rsx_pkg::RSX_OP_XOR_WITH_IMMEDIATE)
                    |=> w_reg == ($past(w_reg) ^ $past(lit))
                        && flags.carry == $past(flags.carry)
                        && flags.digit_carry_flag == $past(flags.digit_carry_flag))
      else $error("immediate xor result or flags wrong");

   AST_XOR_FILE_ZERO:
   assert property (s_take_w(rsx_pkg::RSX_OP_XOR_WITH_FILE_REG)
                    |=> flags.zero == (w_reg == 8'h00) && $stable(flags.carry))
      else $error("file xor zero flag wrong");

   AST_SWAP_NO_FLAGS:
   assert property (s_take_w(rsx_pkg::RSX_OP_NIBBLE_SWAP)
                    |=> flags == $past(flags)
                        && w_reg == {$past(src_file[3:0]), $past(src_file[7:4])})
      else $error("swap changed flags or result wrong");

   AST_ZERO_AFTER_IMM:
   assert property (s_take(rsx_pkg::RSX_OP_SUBTRACT_FROM_IMMEDIATE)
                    |=> flags.zero == (w_reg == 8'h00))
      else $error("zero flag does not match result");

   AST_ONE_CYCLE:
   assert property (s_take(rsx_pkg::RSX_OP_XOR_WITH_IMMEDIATE) ##1 s_idle
                    |-> op_done ##1 !op_done)
      else $error("completion pulse not exactly one cycle");

   AST_FREEZE:
   assert property (!ce |=> $stable(w_reg) && $stable(flags) && $stable(op_done))
      else $error("state moved while clock enable low");

   AST_ROT_TO_FILE:
   assert property (s_take_f(rsx_pkg::RSX_OP_ROTATE_RIGHT_VIA_CARRY)
                    |=> file_q[$past(op_req.file_addr)]
                        == {$past(flags.carry), $past(src_hi7)})
      else $error("rotate result not written back to file");

   AST_SUB_DIGIT:
   assert property ((s_take(rsx_pkg::RSX_OP_SUBTRACT_FROM_IMMEDIATE)
                     or s_take(rsx_pkg::RSX_OP_SUBTRACT_FROM_FILE_REG))
                    |=> flags.digit_carry_flag
                        == ($past(w_reg[3:0]) <= $past(sub_minuend[3:0])))
      else $error("subtract digit carry wrong");

   AST_SUB_FILE_TO_FILE:
   assert property (s_take_f(rsx_pkg::RSX_OP_SUBTRACT_FROM_FILE_REG)
                    |=> file_q[$past(op_req.file_addr)] == 8'($past(src_file) - $past(w_reg))
                        && flags.zero == ($past(src_file) == $past(w_reg)))
      else $error("file subtract not written back to file");

   AST_XOR_FILE_TO_FILE:
   assert property (s_take_f(rsx_pkg::RSX_OP_XOR_WITH_FILE_REG)
                    |=> file_q[$past(op_req.file_addr)] == ($past(w_reg) ^ $past(src_file))
                        && flags.zero == ($past(w_reg) == $past(src_file)))
      else $error("file xor not written back to file");

   AST_SWAP_TO_FILE:
   assert property (s_take_f(rsx_pkg::RSX_OP_NIBBLE_SWAP)
                    |=> file_q[$past(op_req.file_addr)]
                        == {$past(src_file[3:0]), $past(src_file[7:4])}
                        && flags == $past(flags))
      else $error("swap not written back to file or flags moved");

   AST_ZERO_AFTER_XOR:
   assert property (s_take(rsx_pkg::RSX_OP_XOR_WITH_IMMEDIATE)
                    |=> flags.zero == (w_reg == 8'h00))
      else $error("zero flag does not match xor result");

   // Read data may only stand in the cycle after a read strobe
   AST_RD_IDLE:
   assert property (ce && !bus.rd_stb |=> rd_data == 8'h00)
      else $error("read data stood without a read strobe");

endmodule : rsx_alu_core

`default_nettype wire

/* File: rsx_params.svh */
// Summary of operation
// - Rotate right through carry, only carry changes
// - Destination bit: 0 to W, 1 to file
// - Immediate minus W written into W
// - Subtract carry and digit carry mean no borrow
// - File minus W to destination, C DC Z
// - W xor immediate into W, zero only
// - W xor file to destination, zero only
// - Nibble swap to destination, no flags change
`ifndef RSX_PARAMS_SVH
`define RSX_PARAMS_SVH

// ==========================================================================
// Register port map
`define RSX_ADDR_FILE_MAX   8'h7F
`define RSX_ADDR_W_REG      8'h80
`define RSX_ADDR_STATUS     8'h81

// ==========================================================================
// Status register field positions
`define RSX_STAT_CARRY      0
`define RSX_STAT_DIGIT      1
`define RSX_STAT_ZERO       2

// ==========================================================================
// Reset values
`define RSX_W_RESET         8'h00
`define RSX_FILE_RESET      8'h00
`define RSX_RDATA_RESET     8'h00
`define RSX_STATUS_RESET    3'h0

// ==========================================================================
// Timing: result visible this many cycles after issue
`define RSX_OP_LATENCY      1

`endif

/* File: rsx_pkg.sv */
`default_nettype none

// ==========================================================================
// Types shared by the datapath and its users
package rsx_pkg;

   // Operation select
   typedef enum logic [2:0] {
      RSX_OP_ROTATE_RIGHT_VIA_CARRY  = 3'h0,
      RSX_OP_SUBTRACT_FROM_IMMEDIATE = 3'h1,
      RSX_OP_SUBTRACT_FROM_FILE_REG  = 3'h2,
      RSX_OP_XOR_WITH_IMMEDIATE      = 3'h3,
      RSX_OP_XOR_WITH_FILE_REG       = 3'h4,
      RSX_OP_NIBBLE_SWAP             = 3'h5
   } rsx_op_t;

   // One decoded instruction
   typedef struct packed {
      rsx_op_t    op;
      logic [6:0] file_addr;
      logic       dest_file;
      logic [7:0] literal;
   } rsx_req_t;

   // Status flags
   typedef struct packed {
      logic zero;
      logic digit_carry_flag;
      logic carry;
   } rsx_flags_t;

   // Software register port request
   typedef struct packed {
      logic       wr_stb;
      logic       rd_stb;
      logic [7:0] addr;
      logic [7:0] wdata;
   } rsx_bus_req_t;

endpackage : rsx_pkg

`default_nettype wire

/* File: test_rsx_alu_core.sv */
`default_nettype none

// ==========================================================================
// Bench for the rotate, subtract, xor and swap datapath
module test_rsx_alu_core;
   timeunit 1ns;
   timeprecision 1ps;

   logic                  clk_sys;
   logic                  arst_n;
   logic                  ce;
   logic                  op_valid;
   rsx_pkg::rsx_req_t     op_req;
   rsx_pkg::rsx_bus_req_t bus;
   logic [7:0]            rd_data;
   logic [7:0]            w_reg;
   rsx_pkg::rsx_flags_t   flags;
   logic                  op_done;
   int                    mismatches;
   int                    tests_run;
   int                    cycles;
   logic [7:0]            w_in [4] = '{8'h03, 8'h02, 8'hFF, 8'h10};
   logic [7:0]            k_in [4] = '{8'h05, 8'h01, 8'hFF, 8'h0F};

   rsx_alu_core #(.FILE_DEPTH(128)) rsx_alu_core_i (
      .clk_sys  (clk_sys),
      .arst_n   (arst_n),
      .ce       (ce),
      .op_valid (op_valid),
      .op_req   (op_req),
      .bus      (bus),
      .rd_data  (rd_data),
      .w_reg    (w_reg),
      .flags    (flags),
      .op_done  (op_done)
   );

   // ==========================================================================
   // Clock and hang guard, sized well above the roughly one hundred cycles used
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         summarize();
      end
   end

   // ==========================================================================
   // Shared tasks
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic summarize();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : summarize

   // One-cycle write strobe, released on the following edge
   task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      bus <= '{1'b1, 1'b0, a, d};
      @(posedge clk_sys);
      bus <= '0;
   endtask : bus_wr

   // Read data stands one cycle only, then drops back to zero
   task automatic bus_rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      bus <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge clk_sys);
      bus <= '0;
      #1 check("rd_data", rd_data, exp);
      @(posedge clk_sys);
      #1 check("rd_data idle", rd_data, 8'h00);
   endtask : bus_rd

   task automatic run_op(input rsx_pkg::rsx_op_t op, input logic [6:0] fa, input logic d,
                         input logic [7:0] k);
      @(posedge clk_sys);
      op_valid <= 1'b1;
      op_req   <= '{op, fa, d, k};
      @(posedge clk_sys);
      op_valid <= 1'b0;
      #1 check("op_done", {7'h00, op_done}, 8'h01);
   endtask : run_op

   task automatic chk_wf(input logic [7:0] ew, input logic [2:0] ef);
      check("w_reg", w_reg, ew);
      check("flags", {5'h00, flags}, {5'h00, ef});
   endtask : chk_wf

   // ==========================================================================
   // Scenarios
   task automatic t_rotate();
      bus_wr(8'h05, 8'h81);
      bus_wr(8'h81, 8'h04);
      bus_wr(8'h80, 8'h33);
      run_op(rsx_pkg::RSX_OP_ROTATE_RIGHT_VIA_CARRY, 7'h05, 1'b1, 8'h00);
      chk_wf(8'h33, 3'b101);
      bus_rd(8'h05, 8'h40);
      run_op(rsx_pkg::RSX_OP_ROTATE_RIGHT_VIA_CARRY, 7'h05, 1'b0, 8'h00);
      chk_wf(8'hA0, 3'b100);
      bus_rd(8'h05, 8'h40);
   endtask : t_rotate

   // Expected carry and digit carry worked out from the comparisons, zero from the difference
   task automatic t_sub_imm();
      logic [7:0] r;
      for (int i = 0; i < 4; i++) begin
         bus_wr(8'h80, w_in[i]);
         run_op(rsx_pkg::RSX_OP_SUBTRACT_FROM_IMMEDIATE, 7'h00, 1'b0, k_in[i]);
         r = k_in[i] - w_in[i];
         chk_wf(r, {r == 8'h00, w_in[i][3:0] <= k_in[i][3:0], w_in[i] <= k_in[i]});
      end
   endtask : t_sub_imm

   task automatic t_sub_file();
      bus_wr(8'h7F, 8'h10);
      bus_wr(8'h80, 8'h01);
      run_op(rsx_pkg::RSX_OP_SUBTRACT_FROM_FILE_REG, 7'h7F, 1'b1, 8'h00);
      chk_wf(8'h01, 3'b001);
      bus_rd(8'h7F, 8'h0F);
      run_op(rsx_pkg::RSX_OP_SUBTRACT_FROM_FILE_REG, 7'h7F, 1'b0, 8'h00);
      chk_wf(8'h0E, 3'b011);
   endtask : t_sub_file

   task automatic t_xor();
      bus_wr(8'h81, 8'h03);
      bus_wr(8'h80, 8'h5A);
      run_op(rsx_pkg::RSX_OP_XOR_WITH_IMMEDIATE, 7'h00, 1'b0, 8'h5A);
      chk_wf(8'h00, 3'b111);
      bus_wr(8'h12, 8'hF0);
      bus_wr(8'h80, 8'h0F);
      run_op(rsx_pkg::RSX_OP_XOR_WITH_FILE_REG, 7'h12, 1'b1, 8'h00);
      chk_wf(8'h0F, 3'b011);
      bus_rd(8'h12, 8'hFF);
      run_op(rsx_pkg::RSX_OP_XOR_WITH_FILE_REG, 7'h12, 1'b0, 8'h00);
      chk_wf(8'hF0, 3'b011);
   endtask : t_xor

   task automatic t_swap();
      bus_wr(8'h20, 8'h3C);
      bus_wr(8'h81, 8'h05);
      bus_wr(8'h80, 8'h11);
      run_op(rsx_pkg::RSX_OP_NIBBLE_SWAP, 7'h20, 1'b1, 8'h00);
      chk_wf(8'h11, 3'b101);
      bus_rd(8'h20, 8'hC3);
      run_op(rsx_pkg::RSX_OP_NIBBLE_SWAP, 7'h20, 1'b0, 8'h00);
      chk_wf(8'h3C, 3'b101);
   endtask : t_swap

   // Second op must see the first result with no gap between them
   task automatic t_back_to_back();
      bus_wr(8'h80, 8'h01);
      @(posedge clk_sys);
      op_valid <= 1'b1;
      op_req   <= '{rsx_pkg::RSX_OP_SUBTRACT_FROM_IMMEDIATE, 7'h00, 1'b0, 8'h03};
      @(posedge clk_sys);
      op_req   <= '{rsx_pkg::RSX_OP_SUBTRACT_FROM_IMMEDIATE, 7'h00, 1'b0, 8'h02};
      #1 check("w_reg first", w_reg, 8'h02);
      @(posedge clk_sys);
      op_valid <= 1'b0;
      #1 chk_wf(8'h00, 3'b111);
      check("op_done held", {7'h00, op_done}, 8'h01);
      @(posedge clk_sys);
      #1 check("op_done low", {7'h00, op_done}, 8'h00);
   endtask : t_back_to_back

   // Frozen clock enable must leave the working register alone
   task automatic t_ce_low();
      bus_wr(8'h80, 8'h44);
      @(posedge clk_sys);
      ce       <= 1'b0;
      op_valid <= 1'b1;
      op_req   <= '{rsx_pkg::RSX_OP_XOR_WITH_IMMEDIATE, 7'h00, 1'b0, 8'hFF};
      repeat (2) @(posedge clk_sys);
      ce       <= 1'b1;
      op_valid <= 1'b0;
      #1 check("w_reg frozen", w_reg, 8'h44);
      check("op_done frozen", {7'h00, op_done}, 8'h00);
      check("flags frozen", {5'h00, flags}, 8'h07);
      // Unused op code must leave W and flags as they were
      run_op(rsx_pkg::rsx_op_t'(3'h6), 7'h00, 1'b0, 8'hFF);
      chk_wf(8'h44, 3'b111);
   endtask : t_ce_low

   // ==========================================================================
   // Main sequence
   initial begin
      arst_n   = 1'b0;
      ce       = 1'b1;
      op_valid = 1'b0;
      op_req   = '0;
      bus      = '0;
      repeat (5) @(posedge clk_sys);
      arst_n <= 1'b1;
      bus_rd(8'h80, 8'h00);
      bus_rd(8'h81, 8'h00);
      bus_wr(8'h90, 8'hFF);
      bus_rd(8'h90, 8'h00);
      t_rotate();
      t_sub_imm();
      t_sub_file();
      t_xor();
      t_swap();
      t_back_to_back();
      t_ce_low();
      summarize();
   end

endmodule : test_rsx_alu_core

`default_nettype wire
